/* fcf_cmd_flags.v */
// Serial flash command decoder with the operation flag register.
// Assumes a mode-0 host on the serial pins and array/config logic on clk.
`include "fcf_map.vh"
`default_nettype none

module fcf_cmd_flags #(
	parameter DUMMY_CLKS = `FCF_DUMMY_CLKS
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire        ce,
	input  wire [1:0]  proto_sel,
	input  wire        spi_sclk,
	input  wire        spi_cs_n,
	input  wire [3:0]  dq_in,
	output wire [3:0]  dq_out,
	output wire [3:0]  dq_oe_n,
	input  wire        pe_busy,
	input  wire        erase_susp,
	input  wire        prog_susp,
	input  wire        erase_fail,
	input  wire        prog_fail,
	input  wire        zero_to_one,
	input  wire        vpp_high,
	input  wire        pat64,
	input  wire        vpp_bad,
	input  wire        prot_err,
	input  wire [15:0] nv_cfg_in,
	input  wire [7:0]  rd_byte,
	output wire        rd_req,
	output wire [7:0]  flags,
	output wire        wel,
	output wire        cmd_go,
	output wire [7:0]  cmd_code,
	output wire [23:0] cmd_addr,
	output wire        wr_stb,
	output wire [7:0]  wr_byte,
	output wire        nvcfg_wr,
	output wire [15:0] nvcfg_data
);

	localparam ST_CMD   = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_DUMMY = 3'h2;
	localparam ST_OUT   = 3'h3;
	localparam ST_IN    = 3'h4;
	localparam ST_SKIP  = 3'h5;
	localparam integer DUMMY_LAST_N = DUMMY_CLKS - 1;
	localparam [3:0]   DUMMY_LAST   = DUMMY_LAST_N[3:0];

	// ----------------------------------------------------------------
	// Command attributes
	// ----------------------------------------------------------------
	function cmd_ok;
		input [7:0] c;
		input [1:0] p;
		begin
			case (c)
			`FCF_C_ID_SPI0, `FCF_C_ID_SPI1, `FCF_C_RD_SLOW: cmd_ok = (p == `FCF_PROTO_EXT);
			`FCF_C_ID_MULTI: cmd_ok = (p != `FCF_PROTO_EXT);
			`FCF_C_RD_DOUT, `FCF_C_RD_DIO, `FCF_C_PGM_DUAL, `FCF_C_PGM_XDUAL:
				cmd_ok = (p == `FCF_PROTO_EXT) || (p == `FCF_PROTO_DUAL);
			`FCF_C_RD_QOUT, `FCF_C_RD_QIO, `FCF_C_PGM_QUAD, `FCF_C_PGM_XQUAD:
				cmd_ok = (p == `FCF_PROTO_EXT) || (p == `FCF_PROTO_QUAD);
			`FCF_C_RST_EN, `FCF_C_RST_MEM, `FCF_C_RD_DISC, `FCF_C_RD_FAST, `FCF_C_WR_EN,
			`FCF_C_WR_DIS, `FCF_C_RD_STAT, `FCF_C_WR_STAT, `FCF_C_RD_LOCK, `FCF_C_WR_LOCK,
			`FCF_C_RD_FLAG, `FCF_C_CLR_FLAG, `FCF_C_RD_NVCFG, `FCF_C_WR_NVCFG,
			`FCF_C_RD_VCFG, `FCF_C_WR_VCFG, `FCF_C_RD_EVCFG, `FCF_C_WR_EVCFG,
			`FCF_C_PGM_PAGE, `FCF_C_ERS_SUB, `FCF_C_ERS_SECT, `FCF_C_ERS_BULK,
			`FCF_C_RESUME, `FCF_C_SUSPEND, `FCF_C_RD_OTP, `FCF_C_PGM_OTP:
				cmd_ok = (p != 2'h3);
			default: cmd_ok = 1'b0;
			endcase
		end
	endfunction

	function has_addr;
		input [7:0] c;
		begin
			case (c)
			`FCF_C_RD_SLOW, `FCF_C_RD_FAST, `FCF_C_RD_DOUT, `FCF_C_RD_DIO, `FCF_C_RD_QOUT,
			`FCF_C_RD_QIO, `FCF_C_RD_DISC, `FCF_C_RD_OTP, `FCF_C_RD_LOCK, `FCF_C_WR_LOCK,
			`FCF_C_PGM_PAGE, `FCF_C_PGM_DUAL, `FCF_C_PGM_XDUAL, `FCF_C_PGM_QUAD,
			`FCF_C_PGM_XQUAD, `FCF_C_ERS_SUB, `FCF_C_ERS_SECT, `FCF_C_PGM_OTP:
				has_addr = 1'b1;
			default: has_addr = 1'b0;
			endcase
		end
	endfunction

	function has_dummy;
		input [7:0] c;
		begin
			case (c)
			`FCF_C_RD_FAST, `FCF_C_RD_DOUT, `FCF_C_RD_DIO, `FCF_C_RD_QOUT, `FCF_C_RD_QIO,
			`FCF_C_RD_DISC, `FCF_C_RD_OTP: has_dummy = 1'b1;
			default: has_dummy = 1'b0;
			endcase
		end
	endfunction

	function is_out;
		input [7:0] c;
		begin
			case (c)
			`FCF_C_ID_SPI0, `FCF_C_ID_SPI1, `FCF_C_ID_MULTI, `FCF_C_RD_DISC, `FCF_C_RD_SLOW,
			`FCF_C_RD_FAST, `FCF_C_RD_DOUT, `FCF_C_RD_DIO, `FCF_C_RD_QOUT, `FCF_C_RD_QIO,
			`FCF_C_RD_STAT, `FCF_C_RD_LOCK, `FCF_C_RD_FLAG, `FCF_C_RD_NVCFG,
			`FCF_C_RD_VCFG, `FCF_C_RD_EVCFG, `FCF_C_RD_OTP: is_out = 1'b1;
			default: is_out = 1'b0;
			endcase
		end
	endfunction

	// Array-changing commands; these are the ones refused while an error is pending
	function is_array;
		input [7:0] c;
		begin
			case (c)
			`FCF_C_PGM_PAGE, `FCF_C_PGM_DUAL, `FCF_C_PGM_XDUAL, `FCF_C_PGM_QUAD,
			`FCF_C_PGM_XQUAD, `FCF_C_ERS_SUB, `FCF_C_ERS_SECT, `FCF_C_ERS_BULK,
			`FCF_C_PGM_OTP: is_array = 1'b1;
			default: is_array = 1'b0;
			endcase
		end
	endfunction

	function needs_wel;
		input [7:0] c;
		begin
			case (c)
			`FCF_C_WR_STAT, `FCF_C_WR_LOCK, `FCF_C_WR_NVCFG, `FCF_C_WR_VCFG,
			`FCF_C_WR_EVCFG, `FCF_C_RESUME, `FCF_C_SUSPEND: needs_wel = 1'b1;
			default: needs_wel = is_array(c);
			endcase
		end
	endfunction

	// Lanes per clock: whole bus in dual/quad, per-command split in extended
	function [3:0] lanes;
		input [7:0] c;
		input [1:0] p;
		input       ap;
		begin
			if (p == `FCF_PROTO_DUAL)
				lanes = `FCF_LN_2;
			else if (p == `FCF_PROTO_QUAD)
				lanes = `FCF_LN_4;
			else begin
				case (c)
				`FCF_C_RD_DIO, `FCF_C_PGM_XDUAL: lanes = `FCF_LN_2;
				`FCF_C_RD_QIO, `FCF_C_PGM_XQUAD: lanes = `FCF_LN_4;
				`FCF_C_RD_DOUT, `FCF_C_PGM_DUAL: lanes = ap ? `FCF_LN_1 : `FCF_LN_2;
				`FCF_C_RD_QOUT, `FCF_C_PGM_QUAD: lanes = ap ? `FCF_LN_1 : `FCF_LN_4;
				default: lanes = `FCF_LN_1;
				endcase
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	reg       rst_s1_ff;
	reg       rst_s2_ff;
	reg [5:0] pin_s1_ff;
	reg [5:0] pin_s2_ff;
	reg       sclk_d_ff;
	reg       cs_d_ff;
	wire      rst_n = rst_s2_ff;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else if (ce) begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= `FCF_PIN_RST;
			pin_s2_ff <= `FCF_PIN_RST;
			sclk_d_ff <= 1'b0;
			cs_d_ff   <= 1'b1;
		end else if (ce) begin
			pin_s1_ff <= {spi_cs_n, spi_sclk, dq_in};
			pin_s2_ff <= pin_s1_ff;
			sclk_d_ff <= pin_s2_ff[4];
			cs_d_ff   <= pin_s2_ff[5];
		end
	end

	wire       cs_s      = pin_s2_ff[5];
	wire       sclk_s    = pin_s2_ff[4];
	wire [3:0] dq_s      = pin_s2_ff[3:0];
	wire       sclk_rise = sclk_s & ~sclk_d_ff & ~cs_s;
	wire       sclk_fall = ~sclk_s & sclk_d_ff & ~cs_s;
	wire       cs_end    = cs_s & ~cs_d_ff;

	// ----------------------------------------------------------------
	// Frame state
	// ----------------------------------------------------------------
	reg [2:0]  st_ff;
	reg [1:0]  proto_ff;
	reg [3:0]  bcnt_ff;
	reg [7:0]  sr_ff;
	reg [7:0]  code_ff;
	reg [1:0]  acnt_ff;
	reg [23:0] addr_ff;
	reg [3:0]  dcnt_ff;
	reg [7:0]  obyte_ff;
	reg [3:0]  ocnt_ff;
	reg [4:0]  bidx_ff;
	reg [3:0]  dq_out_ff;
	reg [3:0]  dq_oe_n_ff;
	reg        rd_req_ff;
	reg        wr_stb_ff;
	reg [7:0]  wr_byte_ff;
	reg [15:0] nv_ff;
	reg        nv_wr_ff;
	reg        go_ff;
	reg        wel_ff;
	reg [7:0]  flags_ff;
	reg [7:0]  sr_in;
	reg [7:0]  nxt_flags;
	reg [7:0]  byte_v;

	wire [7:0] cur_code = (st_ff == ST_CMD) ? `FCF_C_NONE : code_ff;
	wire [3:0] win      = lanes(cur_code, proto_ff, st_ff == ST_ADDR);
	wire [3:0] wout     = lanes(code_ff, proto_ff, 1'b0);
	wire [3:0] bnext    = bcnt_ff + win;
	wire       full     = (bnext == `FCF_BYTE_BITS);
	wire [3:0] onext    = ocnt_ff + wout;
	wire       arr_src  = (code_ff != `FCF_C_RD_FLAG) && (code_ff != `FCF_C_RD_NVCFG);
	wire       id_spi   = (code_ff == `FCF_C_ID_SPI0) || (code_ff == `FCF_C_ID_SPI1);
	wire       id_mio   = (code_ff == `FCF_C_ID_MULTI);
	wire       is_nvrd  = (code_ff == `FCF_C_RD_NVCFG);
	wire [4:0] lim      = id_spi ? `FCF_ID_SPI_LEN : id_mio ? `FCF_ID_MIO_LEN : `FCF_NV_LEN;
	wire       lim_hit  = (id_spi || id_mio || is_nvrd) && (bidx_ff >= lim);

	// Byte offered at the next output load
	always @* begin
		if (code_ff == `FCF_C_RD_FLAG)
			byte_v = flags_ff;
		else if (lim_hit)
			byte_v = 8'h00;
		else if (is_nvrd)
			byte_v = bidx_ff[0] ? nv_cfg_in[15:8] : nv_cfg_in[7:0];
		else
			byte_v = rd_byte;
		if (ocnt_ff != 4'h0)
			byte_v = obyte_ff;
	end

	always @* begin
		case (win)
		`FCF_LN_2: sr_in = {sr_ff[5:0], dq_s[1:0]};
		`FCF_LN_4: sr_in = {sr_ff[3:0], dq_s[3:0]};
		default:   sr_in = {sr_ff[6:0], dq_s[0]};
		endcase
	end

	// ----------------------------------------------------------------
	// Execution at frame end
	// ----------------------------------------------------------------
	wire any_err  = flags_ff[`FCF_FL_ERS_ERR] | flags_ff[`FCF_FL_PGM_ERR] |
	                flags_ff[`FCF_FL_VPP_ERR] | flags_ff[`FCF_FL_PROT_ERR];
	wire got_code = cs_end && (st_ff != ST_CMD) && (st_ff != ST_SKIP);
	wire blocked  = got_code && is_array(code_ff) && any_err;
	wire wel_miss = needs_wel(code_ff) && !wel_ff;
	wire exec     = got_code && !blocked && !wel_miss;
	wire clr_err  = exec && (code_ff == `FCF_C_CLR_FLAG);

	// ----------------------------------------------------------------
	// Flag register: status bits live, error bits sticky, set beats clear
	// ----------------------------------------------------------------
	always @* begin
		nxt_flags = 8'h00;
		nxt_flags[`FCF_FL_READY]    = ~pe_busy;
		nxt_flags[`FCF_FL_ERS_SUSP] = erase_susp;
		nxt_flags[`FCF_FL_PGM_SUSP] = prog_susp;
		nxt_flags[`FCF_FL_ERS_ERR]  = erase_fail |
			(flags_ff[`FCF_FL_ERS_ERR] & ~clr_err);
		nxt_flags[`FCF_FL_PGM_ERR]  = prog_fail | (zero_to_one & vpp_high & pat64) |
			(flags_ff[`FCF_FL_PGM_ERR] & ~clr_err);
		nxt_flags[`FCF_FL_VPP_ERR]  = vpp_bad |
			(flags_ff[`FCF_FL_VPP_ERR] & ~clr_err);
		nxt_flags[`FCF_FL_PROT_ERR] = prot_err | blocked |
			(flags_ff[`FCF_FL_PROT_ERR] & ~clr_err);
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= `FCF_FL_RST;
			wel_ff   <= 1'b0;
			go_ff    <= 1'b0;
			nv_wr_ff <= 1'b0;
		end else if (ce) begin
			flags_ff <= nxt_flags;
			go_ff    <= exec;
			nv_wr_ff <= exec && (code_ff == `FCF_C_WR_NVCFG) && (bidx_ff == `FCF_NV_LEN);
			if (exec && (code_ff == `FCF_C_WR_EN))
				wel_ff <= 1'b1;
			else if (exec && ((code_ff == `FCF_C_WR_DIS) || needs_wel(code_ff)))
				wel_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff      <= ST_CMD;
			proto_ff   <= `FCF_PROTO_EXT;
			bcnt_ff    <= 4'h0;
			sr_ff      <= 8'h00;
			code_ff    <= `FCF_C_NONE;
			acnt_ff    <= 2'h0;
			addr_ff    <= 24'h000000;
			dcnt_ff    <= 4'h0;
			obyte_ff   <= 8'h00;
			ocnt_ff    <= 4'h0;
			bidx_ff    <= 5'h00;
			dq_out_ff  <= 4'h0;
			dq_oe_n_ff <= `FCF_OE_NONE;
			rd_req_ff  <= 1'b0;
			wr_stb_ff  <= 1'b0;
			wr_byte_ff <= 8'h00;
			nv_ff      <= 16'h0000;
		end else if (ce) begin
			rd_req_ff <= 1'b0;
			wr_stb_ff <= 1'b0;
			if (cs_s) begin
				st_ff      <= ST_CMD;
				proto_ff   <= proto_sel;
				bcnt_ff    <= 4'h0;
				acnt_ff    <= 2'h0;
				dcnt_ff    <= 4'h0;
				ocnt_ff    <= 4'h0;
				bidx_ff    <= 5'h00;
				dq_oe_n_ff <= `FCF_OE_NONE;
			end else if (sclk_rise && (st_ff != ST_OUT) && (st_ff != ST_SKIP)) begin
				sr_ff   <= sr_in;
				bcnt_ff <= full ? 4'h0 : bnext;
				case (st_ff)
				ST_CMD: begin
					if (full) begin
						code_ff <= sr_in;
						if (!cmd_ok(sr_in, proto_ff))
							st_ff <= ST_SKIP;
						else if (has_addr(sr_in))
							st_ff <= ST_ADDR;
						else if (is_out(sr_in)) begin
							st_ff     <= ST_OUT;
							rd_req_ff <= (sr_in != `FCF_C_RD_FLAG) && (sr_in != `FCF_C_RD_NVCFG);
						end else
							st_ff <= ST_IN;
					end
				end
				ST_ADDR: begin
					if (full) begin
						addr_ff <= {addr_ff[15:0], sr_in};
						acnt_ff <= acnt_ff + 2'h1;
						if (acnt_ff == `FCF_ADDR_LAST) begin
							if (has_dummy(code_ff))
								st_ff <= ST_DUMMY;
							else if (is_out(code_ff)) begin
								st_ff     <= ST_OUT;
								rd_req_ff <= 1'b1;
							end else
								st_ff <= ST_IN;
						end
					end
				end
				ST_DUMMY: begin
					bcnt_ff <= 4'h0;
					dcnt_ff <= dcnt_ff + 4'h1;
					if (dcnt_ff == DUMMY_LAST) begin
						st_ff     <= ST_OUT;
						rd_req_ff <= 1'b1;
					end
				end
				ST_IN: begin
					if (full) begin
						wr_stb_ff  <= 1'b1;
						wr_byte_ff <= sr_in;
						if (bidx_ff != `FCF_IDX_MAX)
							bidx_ff <= bidx_ff + 5'h01;
						if (bidx_ff == 5'h00)
							nv_ff[7:0] <= sr_in;
						else if (bidx_ff == 5'h01)
							nv_ff[15:8] <= sr_in;
					end
				end
				default: st_ff <= ST_SKIP;
				endcase
			end else if (sclk_fall && (st_ff == ST_OUT)) begin
				// Host samples on rising edges, so data changes on falling ones
				case (wout)
				`FCF_LN_2: begin
					dq_out_ff  <= {2'b00, byte_v[7:6]};
					dq_oe_n_ff <= `FCF_OE_X2;
				end
				`FCF_LN_4: begin
					dq_out_ff  <= byte_v[7:4];
					dq_oe_n_ff <= `FCF_OE_X4;
				end
				default: begin
					dq_out_ff  <= {2'b00, byte_v[7], 1'b0};
					dq_oe_n_ff <= `FCF_OE_X1;
				end
				endcase
				obyte_ff <= byte_v << wout;
				if (onext == `FCF_BYTE_BITS) begin
					ocnt_ff <= 4'h0;
					if (bidx_ff != `FCF_IDX_MAX)
						bidx_ff <= bidx_ff + 5'h01;
				end else
					ocnt_ff <= onext;
				if (ocnt_ff == 4'h0 && arr_src && !lim_hit)
					rd_req_ff <= 1'b1;
			end
		end
	end

	assign dq_out     = dq_out_ff;
	assign dq_oe_n    = dq_oe_n_ff;
	assign rd_req     = rd_req_ff;
	assign flags      = flags_ff;
	assign wel        = wel_ff;
	assign cmd_go     = go_ff;
	assign cmd_code   = code_ff;
	assign cmd_addr   = addr_ff;
	assign wr_stb     = wr_stb_ff;
	assign wr_byte    = wr_byte_ff;
	assign nvcfg_wr   = nv_wr_ff;
	assign nvcfg_data = nv_ff;

endmodule

`default_nettype wire

/* fcf_map.vh */
// Constants for the flash command decoder and operation flag register.
// Assumes inclusion by bare name from the design file only.
//
// Notes on behaviour
// - Flag bit 7 reads 0 while a program/erase/register write runs, else 1.
// - Flag bit 6 is 1 while an erase is or will be suspended.
// - Flag bit 5 sets on erase failure only, stays 0 on success.
// - Flag bit 4 sets on program failure, or 0-to-1 with high voltage, 64-bit pattern.
// - Flag bit 3 sets on invalid acceleration voltage during program or erase.
// - Flag bit 2 is 1 while a program is or will be suspended.
// - Flag bit 1 sets on protected sector or locked one-time area access.
// - Flag bit 0 reserved; all flags volatile and read with command 70h.
// - Ready and both suspend bits follow their condition, clearing without any command.
// - Error bits hold until command 50h, which has no data, clears them.
// - A program or erase command issued while an error bit is set is refused and flagged in bit 1.
// - Flag read works in every protocol and repeats while clocks continue.
// - Command 3Bh works in extended and dual protocols, streaming bytes without end.
// - Command 6Bh works in extended and quad protocols, streaming bytes without end.
// - Two-line address and data read uses 0Bh, 3Bh or BBh, extended or dual.
// - Four-line address and data read uses 0Bh, 6Bh or EBh, extended or quad.
// - AFh only dual/quad, 1 to 3 bytes; 9E/9Fh only extended, up to 20.
// - Nonvolatile configuration read B5h, write B1h, all protocols, two data bytes.
// - Register commands have no address or dummy, except lock E8h/E5h with 3 address bytes; fast reads take 3 bytes, 8 dummies.
`ifndef FCF_MAP_VH
`define FCF_MAP_VH

`define FCF_PROTO_EXT   2'h0
`define FCF_PROTO_DUAL  2'h1
`define FCF_PROTO_QUAD  2'h2

`define FCF_C_NONE      8'h00
`define FCF_C_RST_EN    8'h66
`define FCF_C_RST_MEM   8'h99
`define FCF_C_ID_SPI0   8'h9E
`define FCF_C_ID_SPI1   8'h9F
`define FCF_C_ID_MULTI  8'hAF
`define FCF_C_RD_DISC   8'h5A
`define FCF_C_RD_SLOW   8'h03
`define FCF_C_RD_FAST   8'h0B
`define FCF_C_RD_DOUT   8'h3B
`define FCF_C_RD_DIO    8'hBB
`define FCF_C_RD_QOUT   8'h6B
`define FCF_C_RD_QIO    8'hEB
`define FCF_C_WR_EN     8'h06
`define FCF_C_WR_DIS    8'h04
`define FCF_C_RD_STAT   8'h05
`define FCF_C_WR_STAT   8'h01
`define FCF_C_RD_LOCK   8'hE8
`define FCF_C_WR_LOCK   8'hE5
`define FCF_C_RD_FLAG   8'h70
`define FCF_C_CLR_FLAG  8'h50
`define FCF_C_RD_NVCFG  8'hB5
`define FCF_C_WR_NVCFG  8'hB1
`define FCF_C_RD_VCFG   8'h85
`define FCF_C_WR_VCFG   8'h81
`define FCF_C_RD_EVCFG  8'h65
`define FCF_C_WR_EVCFG  8'h61
`define FCF_C_PGM_PAGE  8'h02
`define FCF_C_PGM_DUAL  8'hA2
`define FCF_C_PGM_XDUAL 8'hD2
`define FCF_C_PGM_QUAD  8'h32
`define FCF_C_PGM_XQUAD 8'h12
`define FCF_C_ERS_SUB   8'h20
`define FCF_C_ERS_SECT  8'hD8
`define FCF_C_ERS_BULK  8'hC7
`define FCF_C_RESUME    8'h7A
`define FCF_C_SUSPEND   8'h75
`define FCF_C_RD_OTP    8'h4B
`define FCF_C_PGM_OTP   8'h42

`define FCF_FL_READY    7
`define FCF_FL_ERS_SUSP 6
`define FCF_FL_ERS_ERR  5
`define FCF_FL_PGM_ERR  4
`define FCF_FL_VPP_ERR  3
`define FCF_FL_PGM_SUSP 2
`define FCF_FL_PROT_ERR 1
`define FCF_FL_RSVD     0
`define FCF_FL_RST      8'h80

`define FCF_LN_1        4'h1
`define FCF_LN_2        4'h2
`define FCF_LN_4        4'h4
`define FCF_OE_NONE     4'hF
`define FCF_OE_X1       4'hD
`define FCF_OE_X2       4'hC
`define FCF_OE_X4       4'h0
`define FCF_PIN_RST     6'h20
`define FCF_BYTE_BITS   4'h8
`define FCF_ADDR_LAST   2'h2
`define FCF_DUMMY_CLKS  8
`define FCF_ID_SPI_LEN  5'h14
`define FCF_ID_MIO_LEN  5'h03
`define FCF_NV_LEN      5'h02
`define FCF_IDX_MAX     5'h1F

`endif

/* fcf_cmd_flags_chk.sv */
// Checker for the flag register and command outcomes of fcf_cmd_flags.
// Assumes it is bound to that module and sees only its ports.
`default_nettype none
module fcf_cmd_flags_chk #(
	parameter DUMMY_CLKS = 8
) (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       spi_cs_n,
	input wire logic [3:0] dq_oe_n,
	input wire logic       pe_busy,
	input wire logic       erase_susp,
	input wire logic       prog_susp,
	input wire logic       erase_fail,
	input wire logic       prog_fail,
	input wire logic       zero_to_one,
	input wire logic       vpp_high,
	input wire logic       pat64,
	input wire logic       vpp_bad,
	input wire logic       prot_err,
	input wire logic [7:0] flags,
	input wire logic       cmd_go,
	input wire logic [7:0] cmd_code,
	input wire logic       nvcfg_wr
);
	// ------------------------------
	// Settling counter after reset
	// ------------------------------
	logic [2:0] up_ff;
	logic [2:0] nxt_up;
	wire        clr_now = cmd_go && cmd_code == 8'h50;
	wire        ev      = erase_fail || prog_fail || vpp_bad || prot_err ||
	                      (zero_to_one && vpp_high && pat64);
	wire  [7:0] err     = flags & 8'h3A;
	wire        arr_cmd = cmd_code == 8'h20 || cmd_code == 8'hD8 ||
	                      cmd_code == 8'hC7 || cmd_code == 8'h02;

	assign nxt_up = (up_ff == 3'h4) ? up_ff : up_ff + 3'h1;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			up_ff <= 3'h0;
		end else begin
			up_ff <= nxt_up;
		end
	end

	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn || up_ff != 3'h4);

	sequence s_clr;
		clr_now && !$past(ev);
	endsequence
	sequence s_idle;
		spi_cs_n [*5];
	endsequence

	chk_ready_busy: assert property (flags[7] == !$past(pe_busy))
		else $error("Ready bit is not the inverse of busy");
	chk_erase_susp: assert property (flags[6] == $past(erase_susp))
		else $error("Erase suspend bit does not follow its condition");
	chk_prog_susp: assert property (flags[2] == $past(prog_susp))
		else $error("Program suspend bit does not follow its condition");
	chk_erase_err: assert property (erase_fail |=> flags[5])
		else $error("Erase failure not flagged");
	chk_prog_err: assert property ((prog_fail || (zero_to_one && vpp_high && pat64)) |=> flags[4])
		else $error("Program failure not flagged");
	chk_vpp_err: assert property (vpp_bad |=> flags[3])
		else $error("Supply fault not flagged");
	chk_prot_err: assert property (prot_err |=> flags[1])
		else $error("Protection fault not flagged");
	chk_rsvd_zero: assert property (flags[0] == 1'b0)
		else $error("Reserved flag bit is set");
	chk_err_hold: assert property (|($past(err) & ~err) |-> clr_now || $past(clr_now))
		else $error("Error bit dropped without a clear command");
	chk_err_clear: assert property (s_clr |-> ##[0:1] err == 8'h00)
		else $error("Clear command left an error bit set");
	chk_array_refuse: assert property (cmd_go && arr_cmd |-> $past(err) == 8'h00)
		else $error("Array command ran with an error bit set");
	chk_idle_release: assert property (s_idle |-> dq_oe_n == 4'hF)
		else $error("Data lines driven while deselected");
	chk_nv_write: assert property (nvcfg_wr |-> cmd_go && cmd_code == 8'hB1)
		else $error("Configuration write strobe without its command");
endmodule

bind fcf_cmd_flags fcf_cmd_flags_chk #(.DUMMY_CLKS(DUMMY_CLKS)) u_chk (
	.clk(clk), .rstn(rstn), .spi_cs_n(spi_cs_n), .dq_oe_n(dq_oe_n), .pe_busy(pe_busy),
	.erase_susp(erase_susp), .prog_susp(prog_susp), .erase_fail(erase_fail),
	.prog_fail(prog_fail), .zero_to_one(zero_to_one), .vpp_high(vpp_high), .pat64(pat64),
	.vpp_bad(vpp_bad), .prot_err(prot_err), .flags(flags), .cmd_go(cmd_go),
	.cmd_code(cmd_code), .nvcfg_wr(nvcfg_wr)
);
`default_nettype wire

/* fcf_host_model.sv */
// Host controller model: drives serial clock, select and DQ lanes in mode 0.
// Assumes the bench resolves each DQ wire from the device's output enables.
`default_nettype none
module fcf_host_model (
	input  wire logic       clk,
	input  wire logic [3:0] dq_line,
	input  wire logic [3:0] dev_oe_n,
	output var  logic       sclk,
	output var  logic       cs_n,
	output var  logic [3:0] dq_drv
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dq_drv = 4'h0;
	end

	// Half of the 160 ns link period
	task automatic half();
		repeat (4) @(negedge clk);
	endtask

	// Most significant bit first, ln bits per rising edge
	task automatic shift(input logic [23:0] v, input int nb, input int ln);
		for (int i = nb; i > 0; i -= ln) begin
			sclk = 1'b0;
			dq_drv = 4'(v >> (i - ln)) & 4'((1 << ln) - 1);
			half();
			sclk = 1'b1;
			half();
		end
	endtask

	task automatic xfer(input logic [7:0] c, input int cl, input int na, input int al,
		input int nd, input int nw, input logic [15:0] wd, input int nr, input int dl,
		output logic [15:0] rd, output logic drv);
		logic [3:0] ch;
		rd = 16'h0000;
		drv = 1'b0;
		cs_n = 1'b0;
		half();
		shift({16'h0000, c}, 8, cl);
		if (na > 0) shift(24'h00C3A5, 24, al);
		if (nd > 0) shift(24'h000000, nd, 1);
		if (nw > 0) shift({8'h00, wd}, nw * 8, dl);
		// Released lines must not keep the last level
		dq_drv = ~dq_drv;
		for (int i = 0; i < nr * 8; i += dl) begin
			sclk = 1'b0;
			half();
			sclk = 1'b1;
			half();
			ch = dq_line;
			drv = drv | (dev_oe_n != 4'hF);
			rd = (rd << dl) | 16'(dl == 1 ? {3'b000, ch[1]} : (dl == 2 ? {2'b00, ch[1:0]} : ch));
		end
		sclk = 1'b0;
		half();
		cs_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule
`default_nettype wire

/* fcf_cmd_flags_test.sv */
// Self-checking bench for fcf_cmd_flags with a host controller model.
// Assumes the checker is bound to the design and the model drives the link.
`default_nettype none
module fcf_cmd_flags_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DUM = 8;

	logic        clk, rstn, busy, esus, psus, efail, pfail, zto, vhi, p64, vbad, perr, drv;
	logic [1:0]  proto;
	logic [15:0] rd;
	logic [23:0] r;
	logic [35:0] q;
	wire  [3:0]  dq_in, dq_out, dq_oe_n, h_dq;
	wire         sclk, cs_n, cmd_go, nvcfg_wr, wel, rd_req, wr_stb;
	wire  [7:0]  flags, cmd_code, wr_byte;
	wire  [15:0] nvcfg_data;
	wire  [23:0] cmd_addr;
	int          err_count = 0, n_compared = 0, go_cnt = 0, cyc = 0, g;
	int          rq_cnt = 0, ws_cnt = 0;

	// {proto, busy esus psus -, efail pfail vbad perr, zto vhi pat -, flags}
	logic [23:0] frow [0:10] = '{24'h0_0_0_0_80, 24'h0_8_0_0_00, 24'h1_4_0_0_C0,
		24'h2_2_0_0_84, 24'h0_0_8_0_A0, 24'h1_0_4_0_90, 24'h2_0_0_E_90, 24'h0_0_2_0_88,
		24'h1_0_1_0_82, 24'h2_0_0_C_80, 24'h2_8_A_0_28};
	// {proto, code, code lanes, addr lanes, data lanes, driven, first byte}
	logic [35:0] rrow [0:15] = '{36'h0_3B_1_1_2_1_A5, 36'h2_3B_4_4_4_0_00,
		36'h0_6B_1_1_4_1_A5, 36'h1_6B_2_2_2_0_00, 36'h1_BB_2_2_2_1_A5, 36'h2_BB_4_4_4_0_00,
		36'h2_EB_4_4_4_1_A5, 36'h1_EB_2_2_2_0_00, 36'h2_0B_4_4_4_1_A5, 36'h0_BB_1_2_2_1_A5,
		36'h1_AF_2_0_2_1_A5, 36'h0_AF_1_0_1_0_00, 36'h0_9F_1_0_1_1_A5, 36'h2_9E_4_0_4_0_00,
		36'h2_B5_4_0_4_1_C3, 36'h3_70_1_0_1_0_00};

	assign dq_in = (dq_oe_n & h_dq) | (~dq_oe_n & dq_out);

	fcf_cmd_flags #(.DUMMY_CLKS(DUM)) dut (.clk(clk), .rstn(rstn), .ce(1'b1),
		.proto_sel(proto), .spi_sclk(sclk), .spi_cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .pe_busy(busy), .erase_susp(esus), .prog_susp(psus),
		.erase_fail(efail), .prog_fail(pfail), .zero_to_one(zto), .vpp_high(vhi), .pat64(p64),
		.vpp_bad(vbad), .prot_err(perr), .nv_cfg_in(16'h5AC3), .rd_byte(8'hA5),
		.rd_req(rd_req), .flags(flags), .wel(wel), .cmd_go(cmd_go), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .wr_stb(wr_stb), .wr_byte(wr_byte), .nvcfg_wr(nvcfg_wr),
		.nvcfg_data(nvcfg_data));

	fcf_host_model host (.clk(clk), .dq_line(dq_in), .dev_oe_n(dq_oe_n), .sclk(sclk),
		.cs_n(cs_n), .dq_drv(h_dq));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cmd_go === 1'b1) go_cnt++;
		if (rd_req === 1'b1) rq_cnt++;
		if (wr_stb === 1'b1) ws_cnt++;
		if (cyc == 30000) begin
			err_count++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic int lanes(input logic [1:0] p);
		return (p == 2'h0) ? 1 : ((p == 2'h1) ? 2 : 4);
	endfunction

	task automatic cmd(input logic [7:0] c, input int na);
		host.xfer(c, lanes(proto), na, lanes(proto), 0, 0, 16'h0000, 0, lanes(proto), rd, drv);
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		rstn = 1'b0;
		proto = 2'h0;
		{busy, esus, psus, efail, pfail, zto, vhi, p64, vbad, perr} = 10'h000;
		repeat (4) @(negedge clk);
		chk("flags in reset", flags, 8'h80);
		chk("oe in reset", dq_oe_n, 4'hF);
		rstn = 1'b1;
		repeat (10) @(negedge clk);
		for (int i = 0; i < 11; i++) begin
			r = frow[i];
			proto = r[21:20];
			{busy, esus, psus} = r[19:17];
			{efail, pfail, vbad, perr, zto, vhi, p64} = r[15:9];
			@(negedge clk);
			{efail, pfail, vbad, perr, zto, vhi, p64} = 7'h00;
			repeat (3) @(negedge clk);
			chk("flags", flags, r[7:0]);
			host.xfer(8'h70, lanes(proto), 0, 1, 0, 0, 16'h0000, 2, lanes(proto), rd, drv);
			chk("flag read", rd, {r[7:0], r[7:0]});
			cmd(8'h50, 0);
			chk("flag clear", flags, r[7:0] & 8'hC4);
			{busy, esus, psus} = 3'h0;
			repeat (3) @(negedge clk);
			chk("status idle", flags, 8'h80);
		end
		for (int i = 0; i < 16; i++) begin
			q = rrow[i];
			proto = q[33:32];
			g = rq_cnt;
			host.xfer(q[31:24], int'(q[23:20]), (q[19:16] != 4'h0) ? 3 : 0, int'(q[19:16]),
				(q[19:16] != 4'h0) ? DUM : 0, 0, 16'h0000, 1, int'(q[15:12]), rd, drv);
			chk("lanes driven", drv, q[8]);
			if (q[8]) chk("first byte", rd[7:0], q[7:0]);
			chk("read reqs", 24'(rq_cnt - g), (q[8] && q[31:24] != 8'hB5) ? 24'h3 : 24'h0);
		end
		// ------------------------------
		// Write enable, refusal, config write
		// ------------------------------
		proto = 2'h0;
		g = go_cnt;
		cmd(8'h20, 3);
		chk("go without wel", 24'(go_cnt - g), 24'h0);
		cmd(8'h06, 0);
		cmd(8'h20, 3);
		chk("go with wel", 24'(go_cnt - g), 24'h2);
		chk("erase code", cmd_code, 8'h20);
		chk("erase addr", cmd_addr, 24'h00C3A5);
		chk("wel after", wel, 1'b0);
		efail = 1'b1;
		@(negedge clk);
		efail = 1'b0;
		cmd(8'h06, 0);
		cmd(8'hD8, 3);
		chk("go refused", 24'(go_cnt - g), 24'h3);
		chk("refused flags", flags, 8'hA2);
		cmd(8'h50, 0);
		chk("cleared", flags, 8'h80);
		cmd(8'h06, 0);
		host.xfer(8'hB1, 1, 0, 1, 0, 2, 16'h3C96, 0, 1, rd, drv);
		chk("nv data", nvcfg_data, 16'h963C);
		chk("data strobes", 24'(ws_cnt), 24'h2);
		chk("last data byte", wr_byte, 8'h96);
		chk("go nv", 24'(go_cnt - g), 24'h6);
		close_out();
	end
endmodule
`default_nettype wire
